/* File: rtl/assc_pkg.sv */
// Constants for the address space select and check block.
// Assumes a single core clock; space values are 8-bit identifiers, request kinds a 2-bit enum.
package assc_pkg;
   localparam int SPACE_W = 8;
   // Implicit space codes; the values are arbitrary
   localparam logic [7:0] PRIMARY_SPACE = 8'h80;
   localparam logic [7:0] PRIMARY_SPACE_LE = 8'h88;
   localparam logic [7:0] KERNEL_SPACE = 8'h04;
   localparam logic [7:0] KERNEL_SPACE_LE = 8'h0c;
   // Range limits of the privilege classes
   localparam logic [7:0] SUPV_LAST = 8'h2f;
   localparam logic [7:0] HYPER_LAST = 8'h7f;
   localparam logic [7:0] SPACE_RESET = 8'h00;
   typedef enum logic [1:0] {
      ASSC_KIND_FETCH,
      ASSC_KIND_DATA,
      ASSC_KIND_ALT
   } assc_kind_t;
endpackage

/* File: rtl/assc_priv_check.sv */
// Privilege check of one space identifier against the current mode.
// Purely combinational; caller registers the result.
`timescale 1ns/1ps
module assc_priv_check (
   input wire logic [7:0] space,
   input wire logic hyper_mode_bit,
   input wire logic supervisor_bit,
   output logic fault
);
   always_comb begin
      // Full 8-bit compares, no bit subset decoded
      if (space <= assc_pkg::SUPV_LAST) begin
         fault = !hyper_mode_bit && !supervisor_bit;
      end else if (space <= assc_pkg::HYPER_LAST) begin
         fault = !hyper_mode_bit;
      end else begin
         fault = 1'b0;
      end
   end
endmodule // assc_priv_check

/* File: rtl/assc_top.sv */
// Address space select and privilege check for fetch and load/store.
// Assumes a one-cycle request pulse from the pipeline, answered next cycle.
// Functional notes
// - Alternate access: immediate field, or register if select=1
// - Fetch: primary at level 0, kernel above
// - Data: same choice, little-endian variant when flag set
// - Hyperprivileged mode supplies no implicit identifier
// - Alternate access uses explicit identifier always
// - 0x00-0x2F fault only in nonprivileged mode
// - 0x30-0x7F allowed only in hyperprivileged mode
// - 0x80-0xFF allowed in every mode
// - All eight identifier bits decoded
`timescale 1ns/1ps
module assc_top (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic REQ_VALID,
   input wire logic [1:0] REQ_KIND,
   input wire logic IMM_SELECT,
   input wire logic [7:0] IMM_SPACE,
   input wire logic [7:0] SPACE_REG,
   input wire logic [2:0] TRAP_LEVEL,
   input wire logic CURRENT_LITTLE_ENDIAN_FLAG,
   input wire logic HYPER_MODE_BIT,
   input wire logic SUPERVISOR_BIT,
   output logic ACC_VALID,
   output logic [7:0] ACC_SPACE,
   output logic ACC_PHYSICAL,
   output logic PRIV_FAULT
);
   // Which source supplies the identifier of the current request
   typedef enum logic [1:0] {
      ASSC_PATH_EXPLICIT,
      ASSC_PATH_PHYSICAL,
      ASSC_PATH_IMPLICIT
   } assc_path_t;

   logic is_fetch;
   logic is_alt;
   logic is_data;
   logic level_zero;
   assc_path_t path;
   logic [7:0] explicit_space;
   logic [7:0] fetch_space;
   logic [7:0] data_space;
   logic [7:0] implicit_space;
   logic [7:0] space_d;
   logic phys_d;
   logic fault_raw;
   logic fault_d;
   logic acc_valid_d;
   logic acc_valid_q;
   logic [7:0] acc_space_q;
   logic acc_phys_q;
   logic fault_q;

   // Kind compare at full width; code 3 is neither and falls to data
   function automatic logic kind_is(
      input logic [1:0] kind,
      input assc_pkg::assc_kind_t want
   );
      return kind == 2'(want);
   endfunction

   // Only zero against nonzero matters for the trap level
   function automatic logic at_level_zero(
      input logic [2:0] level
   );
      return level == 3'h0;
   endfunction

   // Little-endian variant chosen by the flag
   function automatic logic [7:0] pick_endian(
      input logic little,
      input logic [7:0] normal_space,
      input logic [7:0] little_space
   );
      logic [7:0] result;
      if (little) begin
         result = little_space;
      end else begin
         result = normal_space;
      end
      return result;
   endfunction

   // Hyper mode overrides implicit kinds only; alternate keeps its id
   function automatic assc_path_t path_of(
      input logic alt,
      input logic hyper
   );
      assc_path_t result;
      if (alt) begin
         result = ASSC_PATH_EXPLICIT;
      end else if (hyper) begin
         result = ASSC_PATH_PHYSICAL;
      end else begin
         result = ASSC_PATH_IMPLICIT;
      end
      return result;
   endfunction

   // Request decode
   assign is_alt = kind_is(REQ_KIND, assc_pkg::ASSC_KIND_ALT);
   assign is_fetch = kind_is(REQ_KIND, assc_pkg::ASSC_KIND_FETCH);
   assign is_data = !is_alt && !is_fetch;
   assign level_zero = at_level_zero(TRAP_LEVEL);
   assign path = path_of(is_alt, HYPER_MODE_BIT);

   // Explicit identifier, independent of level and endianness
   always_comb begin
      if (IMM_SELECT) begin
         explicit_space = SPACE_REG;
      end else begin
         explicit_space = IMM_SPACE;
      end
   end

   // Fetch ignores the endianness flag
   always_comb begin
      if (level_zero) begin
         fetch_space = assc_pkg::PRIMARY_SPACE;
      end else begin
         fetch_space = assc_pkg::KERNEL_SPACE;
      end
   end

   always_comb begin
      if (level_zero) begin
         data_space = pick_endian(CURRENT_LITTLE_ENDIAN_FLAG, assc_pkg::PRIMARY_SPACE,
                                  assc_pkg::PRIMARY_SPACE_LE);
      end else begin
         data_space = pick_endian(CURRENT_LITTLE_ENDIAN_FLAG, assc_pkg::KERNEL_SPACE,
                                  assc_pkg::KERNEL_SPACE_LE);
      end
   end

   always_comb begin
      if (is_data) begin
         implicit_space = data_space;
      end else begin
         implicit_space = fetch_space;
      end
   end

   always_comb begin
      space_d = assc_pkg::SPACE_RESET;
      phys_d = 1'b0;
      unique case (path)
         ASSC_PATH_EXPLICIT: begin
            space_d = explicit_space;
         end
         ASSC_PATH_PHYSICAL: begin
            // Physical addressing, no implicit identifier
            phys_d = 1'b1;
         end
         ASSC_PATH_IMPLICIT: begin
            space_d = implicit_space;
         end
      endcase
   end

   // Implicit identifiers are always legal for the mode that made them,
   // so only explicit ones go through the range check.
   assc_priv_check u_check (
      .space(space_d),
      .hyper_mode_bit(HYPER_MODE_BIT),
      .supervisor_bit(SUPERVISOR_BIT),
      .fault(fault_raw)
   );

   always_comb begin
      fault_d = 1'b0;
      acc_valid_d = 1'b0;
      if (REQ_VALID) begin
         // Range check applies to explicit identifiers only
         fault_d = is_alt && fault_raw;
         // A faulting access never reaches memory
         acc_valid_d = !fault_d;
      end
   end

   // Strobes last one cycle; identifier and physical flag hold
   // until the next request so the translation path can reuse them.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_valid_q <= 1'b0;
      end else begin
         acc_valid_q <= acc_valid_d;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_space_q <= assc_pkg::SPACE_RESET;
      end else if (REQ_VALID) begin
         acc_space_q <= space_d;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_phys_q <= 1'b0;
      end else if (REQ_VALID) begin
         acc_phys_q <= phys_d;
      end
   end

   // Data outputs straight from flip-flops
   assign ACC_VALID = acc_valid_q;
   assign ACC_SPACE = acc_space_q;
   assign ACC_PHYSICAL = acc_phys_q;
   assign PRIV_FAULT = fault_q;
endmodule // assc_top

/* File: verification/assc_top_sva.sv */
// Port checker for assc_top; one clock, bound at the foot of this file.
`timescale 1ns/1ps
module assc_top_sva(input wire logic MCLK, RESETN, REQ_VALID, IMM_SELECT,
   CURRENT_LITTLE_ENDIAN_FLAG, HYPER_MODE_BIT, SUPERVISOR_BIT, ACC_VALID, ACC_PHYSICAL,
   PRIV_FAULT, input wire logic [1:0] REQ_KIND, input wire logic [2:0] TRAP_LEVEL,
   input wire logic [7:0] IMM_SPACE, SPACE_REG, ACC_SPACE);
default clocking @(posedge MCLK); endclocking
default disable iff (!RESETN);
wire [7:0] x = IMM_SELECT ? SPACE_REG : IMM_SPACE;
wire t = |TRAP_LEVEL, q = REQ_VALID && REQ_KIND != 2'h2, h = HYPER_MODE_BIT;
wire a = REQ_VALID && !q, f = !x[7] && !h && (!SUPERVISOR_BIT || x > 8'h2f);
AST_SEL: assert property (a |=> ACC_SPACE == $past(x))
   else $error("sel");
AST_FETCH: assert property (q && !h && REQ_KIND == 2'h0 |=>
   ACC_SPACE == $past({!t, 4'h0, t, 2'h0})) else $error("fetch");
AST_DATA: assert property (q && !h && REQ_KIND[0] |=>
   ACC_SPACE == $past({!t, 3'h0, CURRENT_LITTLE_ENDIAN_FLAG, t, 2'h0})) else $error("data");
AST_PHYS: assert property (q && h |=> ACC_PHYSICAL && ACC_SPACE == 8'h00)
   else $error("phys");
AST_FLT: assert property (a && f |=> PRIV_FAULT) else $error("flt");
AST_OK: assert property (a && !f |=> ACC_VALID) else $error("ok");
AST_ONE: assert property (REQ_VALID |=> ACC_VALID != PRIV_FAULT) else $error("one");
AST_IDLE: assert property (!REQ_VALID |=> !ACC_VALID && !PRIV_FAULT) else $error("idle");
endmodule // assc_top_sva
bind assc_top assc_top_sva SVA(.*);

/* File: verification/assc_sink.sv */
// Far-side model: translation path counting forwarded accesses.
`timescale 1ns/1ps
module assc_sink(input wire logic clk, rst_n, acc_valid, output int count);
always_ff @(posedge clk or negedge rst_n) count <= rst_n ? count + acc_valid : 0;
endmodule // assc_sink

/* File: verification/assc_top_tb.sv */
// Bench for assc_top: back-to-back explicit and implicit requests.
`timescale 1ns/1ps
module assc_top_tb;
logic c = 0, r = 0, v = 0, e = 0, f, av, ap, pf;
logic [1:0] k = 0;
logic [2:0] l = 0, m = 0;
logic [7:0] i = 0, g = 0, as, x;
logic [7:0] ids [6] = '{8'h00, 8'h2f, 8'h30, 8'h7f, 8'h80, 8'hff};
int bad_count = 0, check_count = 0, n = 0, cnt;
assc_top DUT(.MCLK(c), .RESETN(r), .REQ_VALID(v), .REQ_KIND(k), .IMM_SELECT(e), .IMM_SPACE(i),
   .SPACE_REG(g), .TRAP_LEVEL(l), .CURRENT_LITTLE_ENDIAN_FLAG(m[2]), .HYPER_MODE_BIT(m[1]),
   .SUPERVISOR_BIT(m[0]), .ACC_VALID(av), .ACC_SPACE(as), .ACC_PHYSICAL(ap), .PRIV_FAULT(pf));
assc_sink SNK(.clk(c), .rst_n(r), .acc_valid(av), .count(cnt));
initial forever #50 c = ~c;
task cmp(string s, logic [10:0] w, y);
   check_count++;
   if (w !== y) bad_count++;
   if (w !== y) $display("Error %s expected %h seen %h", s, w, y);
endtask
task rq(logic [1:0] q, logic [7:0] d);
   {k, v, e} = {q, 1'h1, ~e};
   {i, g} = e ? {~d, d} : {d, ~d};
   @(negedge c);
endtask
task t_alt;
   for (int j = 0; j < 48; j++) begin
      {l, m, x} = {j[3], 2'h0, j[2:0], ids[j / 8]};
      f = !x[7] && !m[1] && (!m[0] || x > 8'h2f);
      n += !f;
      rq(2'h2, x);
      cmp("alt", {!f, f, 1'h0, x}, {av, pf, ap, as});
   end
endtask
task t_imp;
   for (int j = 0; j < 32; j++) begin
      {l, m} = {j[0], 2'h0, j[1], j[2], 1'h0};
      x = j[2] ? 8'h00 : {!j[0], 3'h0, j[1] & j[3], j[0], 2'h0};
      n++;
      rq({j[4] & j[3], j[3]}, 8'h5a);
      cmp("imp", {2'h2, j[2], x}, {av, pf, ap, as});
   end
endtask
task complete_run;
   $display("Checks %0d errors %0d", check_count, bad_count);
   if (bad_count == 0 && check_count > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
endtask
initial begin
   repeat (5) @(negedge c);
   cmp("rst", 11'h0, {av, pf, ap, as});
   r = 1;
   t_alt();
   t_imp();
   v = 0;
   repeat (2) @(negedge c);
   cmp("sink", n, cnt);
   cmp("hold", 11'h100, {av, pf, ap, as});
   complete_run();
end
initial begin
   #20000 bad_count++;
   complete_run();
end
endmodule // assc_top_tb
